// file: core_regs_pkg.sv
// constants and types for the core register file and read-only window
package core_regs_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 12;
  localparam int PAGE_W = 6;
  localparam int LOW_W = 6;
  localparam logic [7:0] ADDR_INDEX_POINTER_FIRST = 8'h80;
  localparam logic [7:0] ADDR_INDEX_POINTER_SECOND = 8'h81;
  localparam logic [7:0] ADDR_SHORT_DIRECT_FIRST = 8'h82;
  localparam logic [7:0] ADDR_SHORT_DIRECT_SECOND = 8'h83;
  localparam logic [7:0] ADDR_ROM_WINDOW_PAGE = 8'hc9;
  localparam logic [7:0] ADDR_ACCUMULATOR_REG = 8'hff;
  localparam logic [7:0] ADDR_WINDOW_FIRST = 8'h40;
  localparam logic [7:0] ADDR_WINDOW_LAST = 8'h7f;
  localparam logic [7:0] READ_FILL = 8'h00;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] PC_STEP = 12'h001;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [1:0] PAIR_NORMAL = 2'h0;
  localparam logic [1:0] PAIR_INT = 2'h1;
  localparam logic [1:0] PAIR_NMI = 2'h2;

  typedef enum logic [1:0] {
    PC_HOLD = 2'b00,
    PC_INC = 2'b01,
    PC_LOAD = 2'b10,
    PC_REL = 2'b11
  } pc_op_t;

  typedef enum logic [1:0] {
    CTX_NORMAL = 2'b00,
    CTX_INT = 2'b01,
    CTX_NMI = 2'b10
  } ctx_t;

  typedef enum logic [1:0] {
    WIN_IDLE = 2'b00,
    WIN_MEM = 2'b01,
    WIN_DATA = 2'b10
  } win_state_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] ptr_first;
    logic [7:0] ptr_second;
    logic [7:0] sd_first;
    logic [7:0] sd_second;
    logic [11:0] pc;
    logic [2:0] carry;
    logic [2:0] zero;
    logic carry_out;
    logic zero_out;
    logic [7:0] ind_addr;
    logic [7:0] rdata;
    logic rvalid;
    logic hit;
    logic [11:0] pm_addr;
    logic pm_rd;
    logic busy;
    win_state_t wstate;
  } core_state_t;

  typedef struct packed {
    logic [5:0] page;
  } page_state_t;
endpackage

// file: window_if.sv
// signals between the core register file and the window page unit
`timescale 1ns/10ps
interface window_if;
  logic page_wr;
  logic [7:0] page_wdata;
  logic [5:0] low_addr;
  logic [11:0] pm_addr;
  modport core(output page_wr, output page_wdata, output low_addr, input pm_addr);
  modport page(input page_wr, input page_wdata, input low_addr, output pm_addr);
endinterface

// file: window_page_unit.sv
// write-only window page register and program memory address former
`timescale 1ns/10ps
module window_page_unit (
  input wire logic sys_clk,       // machine clock
  window_if.page win              // page write and address forming
);
  core_regs_pkg::page_state_t st;
  core_regs_pkg::page_state_t next_st;

  always_comb begin
    next_st = st;
    if (win.page_wr) begin
      next_st.page = win.page_wdata[core_regs_pkg::PAGE_W-1:0];
    end
  end

  // no reset: content unknown until first write
  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign win.pm_addr = {st.page, win.low_addr};
endmodule

// file: core_regs_rom_data_window.sv
// core working registers, program counter, flags and read-only data window
`timescale 1ns/10ps
module core_regs_rom_data_window (
  input wire logic sys_clk,                 // machine clock
  input wire logic rst_n,                   // async reset, active low
  input wire logic [7:0] ds_addr,           // data-space address
  input wire logic ds_rd,                   // data-space read strobe
  input wire logic ds_wr,                   // data-space write strobe
  input wire logic [7:0] ds_wdata,          // data-space write data
  output logic [7:0] ds_rdata,              // read data
  output logic ds_rvalid,                   // read data valid pulse
  output logic ds_hit,                      // read served by this block
  output logic win_busy,                    // window read in progress
  output logic [11:0] pm_addr,              // window program memory address
  output logic pm_rd,                       // window program memory read pulse
  input wire logic [7:0] pm_rdata,          // program memory data, one cycle after pm_rd
  input wire logic acc_we,                  // alu writes accumulator
  input wire logic [7:0] acc_wdata,         // alu result
  output logic [7:0] accumulator_reg,       // accumulator content
  input wire logic ind_sel,                 // 0 first pointer, 1 second
  output logic [7:0] ind_addr,              // indirect operand address
  input wire logic [1:0] pc_op,             // program counter operation
  input wire logic [11:0] pc_load_value,    // jump, call, vector or pop value
  input wire logic [7:0] pc_offset,         // signed relative branch offset
  output logic [11:0] program_counter,      // next fetch address
  input wire logic [1:0] ctx,               // execution context
  input wire logic flag_we,                 // update flags of context
  input wire logic carry_in,                // new carry
  input wire logic zero_in,                 // new zero
  output logic carry,                       // carry of current context
  output logic zero                         // zero of current context
);
  core_regs_pkg::core_state_t st;
  core_regs_pkg::core_state_t next_st;
  window_if win ();

  logic in_window;
  logic page_sel;
  logic [1:0] flag_idx;
  logic [11:0] rel_step;
  logic [11:0] pc_next;
  logic [7:0] reg_rdata;
  logic reg_hit;
  logic access_ok;
  logic [2:0] next_carry;
  logic [2:0] next_zero;

  window_page_unit u_page (
    .sys_clk(sys_clk),
    .win(win.page)
  );

  assign in_window = (ds_addr >= core_regs_pkg::ADDR_WINDOW_FIRST) &&
                     (ds_addr <= core_regs_pkg::ADDR_WINDOW_LAST);
  assign page_sel = (ds_addr == core_regs_pkg::ADDR_ROM_WINDOW_PAGE);
  // a window read holds the port; nothing is taken then
  assign access_ok = (st.wstate == core_regs_pkg::WIN_IDLE);
  assign win.page_wr = ds_wr && page_sel && access_ok;
  assign win.page_wdata = ds_wdata;
  assign win.low_addr = ds_addr[core_regs_pkg::LOW_W-1:0];
  assign rel_step = {{(core_regs_pkg::PC_W-core_regs_pkg::DATA_W){pc_offset[7]}}, pc_offset};

  always_comb begin
    case (ctx)
      core_regs_pkg::CTX_NORMAL: flag_idx = core_regs_pkg::PAIR_NORMAL;
      core_regs_pkg::CTX_INT: flag_idx = core_regs_pkg::PAIR_INT;
      default: flag_idx = core_regs_pkg::PAIR_NMI;
    endcase
  end

  // register read mux; page and unmapped reads give the fill byte
  always_comb begin
    reg_rdata = core_regs_pkg::READ_FILL;
    reg_hit = 1'b1;
    case (ds_addr)
      core_regs_pkg::ADDR_INDEX_POINTER_FIRST: reg_rdata = st.ptr_first;
      core_regs_pkg::ADDR_INDEX_POINTER_SECOND: reg_rdata = st.ptr_second;
      core_regs_pkg::ADDR_SHORT_DIRECT_FIRST: reg_rdata = st.sd_first;
      core_regs_pkg::ADDR_SHORT_DIRECT_SECOND: reg_rdata = st.sd_second;
      core_regs_pkg::ADDR_ACCUMULATOR_REG: reg_rdata = st.acc;
      core_regs_pkg::ADDR_ROM_WINDOW_PAGE: reg_rdata = core_regs_pkg::READ_FILL;
      default: reg_hit = 1'b0;
    endcase
  end

  // program counter, wraps within 4096 bytes
  always_comb begin
    case (core_regs_pkg::pc_op_t'(pc_op))
      core_regs_pkg::PC_INC: pc_next = st.pc + core_regs_pkg::PC_STEP;
      core_regs_pkg::PC_LOAD: pc_next = pc_load_value;
      core_regs_pkg::PC_REL: pc_next = st.pc + rel_step;
      default: pc_next = st.pc;
    endcase
  end

  // one carry/zero pair per context; the others keep their state
  always_comb begin
    next_carry = st.carry;
    next_zero = st.zero;
    if (flag_we) begin
      next_carry[flag_idx] = carry_in;
      next_zero[flag_idx] = zero_in;
    end
  end

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.pm_rd = 1'b0;

    // data-space register writes; window writes do nothing
    if (ds_wr && access_ok) begin
      case (ds_addr)
        core_regs_pkg::ADDR_INDEX_POINTER_FIRST: next_st.ptr_first = ds_wdata;
        core_regs_pkg::ADDR_INDEX_POINTER_SECOND: next_st.ptr_second = ds_wdata;
        core_regs_pkg::ADDR_SHORT_DIRECT_FIRST: next_st.sd_first = ds_wdata;
        core_regs_pkg::ADDR_SHORT_DIRECT_SECOND: next_st.sd_second = ds_wdata;
        core_regs_pkg::ADDR_ACCUMULATOR_REG: next_st.acc = ds_wdata;
        default: next_st.acc = next_st.acc;
      endcase
    end
    // alu result wins over a same-cycle data-space write
    if (acc_we) begin
      next_st.acc = acc_wdata;
    end

    // read path and window sequence
    case (st.wstate)
      core_regs_pkg::WIN_IDLE: begin
        if (ds_rd && !ds_wr) begin
          if (in_window) begin
            next_st.pm_addr = win.pm_addr;
            next_st.pm_rd = 1'b1;
            next_st.busy = 1'b1;
            next_st.wstate = core_regs_pkg::WIN_MEM;
          end else begin
            next_st.rvalid = 1'b1;
            next_st.hit = reg_hit;
            next_st.rdata = reg_rdata;
          end
        end
      end
      core_regs_pkg::WIN_MEM: begin
        next_st.wstate = core_regs_pkg::WIN_DATA;
      end
      // program memory answers one cycle after pm_rd
      core_regs_pkg::WIN_DATA: begin
        next_st.rdata = pm_rdata;
        next_st.rvalid = 1'b1;
        next_st.hit = 1'b1;
        next_st.busy = 1'b0;
        next_st.wstate = core_regs_pkg::WIN_IDLE;
      end
      default: begin
        next_st.busy = 1'b0;
        next_st.wstate = core_regs_pkg::WIN_IDLE;
      end
    endcase

    next_st.pc = pc_next;

    next_st.carry = next_carry;
    next_st.zero = next_zero;
    next_st.carry_out = next_carry[flag_idx];
    next_st.zero_out = next_zero[flag_idx];

    // operand address follows the selected pointer
    next_st.ind_addr = ind_sel ? next_st.ptr_second : next_st.ptr_first;
  end

  // page register sits in the unit, outside this reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{
        acc: core_regs_pkg::REG_RESET,
        ptr_first: core_regs_pkg::REG_RESET,
        ptr_second: core_regs_pkg::REG_RESET,
        sd_first: core_regs_pkg::REG_RESET,
        sd_second: core_regs_pkg::REG_RESET,
        pc: core_regs_pkg::PC_RESET,
        carry: core_regs_pkg::FLAGS_RESET,
        zero: core_regs_pkg::FLAGS_RESET,
        carry_out: 1'b0,
        zero_out: 1'b0,
        ind_addr: core_regs_pkg::REG_RESET,
        rdata: core_regs_pkg::READ_FILL,
        rvalid: 1'b0,
        hit: 1'b0,
        pm_addr: core_regs_pkg::PC_RESET,
        pm_rd: 1'b0,
        busy: 1'b0,
        wstate: core_regs_pkg::WIN_IDLE
      };
    end else begin
      st <= next_st;
    end
  end

  assign ds_rdata = st.rdata;
  assign ds_rvalid = st.rvalid;
  assign ds_hit = st.hit;
  assign win_busy = st.busy;
  assign pm_addr = st.pm_addr;
  assign pm_rd = st.pm_rd;
  assign accumulator_reg = st.acc;
  assign ind_addr = st.ind_addr;
  assign program_counter = st.pc;
  assign carry = st.carry_out;
  assign zero = st.zero_out;
endmodule

// file: prog_mem_model.sv
// program memory model answering window reads
`timescale 1ns/10ps
module prog_mem_model (
  input wire logic sys_clk, // clock
  input wire logic pm_rd, // read pulse
  input wire logic [11:0] pm_addr, // read address
  output logic [7:0] pm_rdata // data, valid the cycle after pm_rd
);
  initial begin
    pm_rdata = 8'h00;
  end
  // outside the read cycle the bus inverts its byte every cycle
  always @(posedge sys_clk) begin
    if (pm_rd) begin
      pm_rdata <= pm_addr[7:0] ^ {pm_addr[11:6], 2'b01};
    end else begin
      pm_rdata <= ~pm_rdata;
    end
  end
endmodule

// file: core_regs_rom_data_window_assertions.sv
// port assertions for the core register file
`timescale 1ns/10ps
module core_regs_checker (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [7:0] ds_addr, // in
  input wire logic ds_rd, // in
  input wire logic ds_wr, // in
  input wire logic [7:0] ds_wdata, // in
  input wire logic [7:0] ds_rdata, // out
  input wire logic ds_rvalid, // out
  input wire logic ds_hit, // out
  input wire logic win_busy, // out
  input wire logic [11:0] pm_addr, // out
  input wire logic pm_rd, // out
  input wire logic acc_we, // in
  input wire logic [7:0] accumulator_reg, // out
  input wire logic ind_sel, // in
  input wire logic [7:0] ind_addr, // out
  input wire logic [1:0] pc_op, // in
  input wire logic [11:0] program_counter, // out
  input wire logic flag_we, // in
  input wire logic carry_in, // in
  input wire logic zero_in, // in
  input wire logic carry, // out
  input wire logic zero // out
);
  logic win_req;
  assign win_req = ds_rd && !ds_wr && !win_busy && ds_addr[7:6] == 2'b01;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  win_start_a: assert property (win_req |=> pm_rd && pm_addr[5:0] == $past(ds_addr[5:0]))
    else $error("window read start wrong");
  win_answer_a: assert property (pm_rd |=> !pm_rd ##1 ds_rvalid && ds_hit)
    else $error("window answer late");
  busy_span_a: assert property (win_req |=> win_busy [*2] ##1 !win_busy)
    else $error("busy span wrong");
  page_read_a: assert property (ds_rd && !ds_wr && !win_busy && ds_addr == 8'hc9 |=> ds_rvalid && ds_rdata == 8'h00)
    else $error("page read not empty");
  acc_write_a: assert property (ds_wr && !win_busy && !acc_we && ds_addr == 8'hff |=> accumulator_reg == $past(ds_wdata))
    else $error("accumulator write lost");
  ptr_write_a: assert property (ds_wr && !win_busy && !ind_sel && ds_addr == 8'h80 |=> ind_addr == $past(ds_wdata))
    else $error("pointer address wrong");
  pc_step_a: assert property (pc_op == 2'b01 |=> program_counter == $past(program_counter) + 12'h001)
    else $error("counter step wrong");
  flag_update_a: assert property (flag_we |=> carry == $past(carry_in) && zero == $past(zero_in))
    else $error("flag update wrong");
endmodule

// file: core_regs_rom_data_window_tb.sv
// self-checking bench for the core register file
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("FAIL %0t got %h want %h", $time, g, e); end end
module core_regs_rom_data_window_tb;
  logic sys_clk, rst_n, ds_rd, ds_wr, acc_we, ind_sel, flag_we, carry_in, zero_in, ds_rvalid, ds_hit, win_busy, pm_rd;
  logic carry, zero;
  logic [7:0] ds_addr, ds_wdata, pm_rdata, acc_wdata, pc_offset, ds_rdata, accumulator_reg, ind_addr, page;
  logic [11:0] pm_addr, pc_load_value, program_counter;
  logic [1:0] pc_op, ctx;
  logic [8:0] exp_q[$];
  logic [8:0] exp_note;
  logic [7:0] regv[6];
  int n_errors = 0;
  int total_checks = 0;
  core_regs_rom_data_window core_regs_rom_data_window_inst(.sys_clk, .rst_n, .ds_addr, .ds_rd, .ds_wr, .ds_wdata,
    .ds_rdata, .ds_rvalid, .ds_hit, .win_busy, .pm_addr, .pm_rd, .pm_rdata, .acc_we, .acc_wdata, .accumulator_reg,
    .ind_sel, .ind_addr, .pc_op, .pc_load_value, .pc_offset, .program_counter, .ctx, .flag_we, .carry_in, .zero_in,
    .carry, .zero);
  prog_mem_model prog_mem_model_inst(.sys_clk, .pm_rd, .pm_addr, .pm_rdata);
  function automatic logic [8:0] win(input logic [5:0] low);
    logic [11:0] a;
    a = {page[5:0], low};
    return {1'b1, a[7:0] ^ {a[11:6], 2'b01}};
  endfunction
  // strobe for one edge, then g idle edges
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input int g = 2);
    ds_wr = w;
    ds_rd = !w;
    ds_addr = a;
    ds_wdata = d;
    @(posedge sys_clk);
    if (g > 0) begin
      #1 ds_wr = 1'b0;
      ds_rd = 1'b0;
      repeat (g) @(posedge sys_clk);
    end
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e, input int g = 2);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00, g);
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (ds_rvalid === 1'b1) begin
      exp_note = (exp_q.size() != 0) ? exp_q.pop_front() : 9'bx;
      `CHK({ds_hit, ds_rdata}, exp_note)
    end
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    results();
  end
  initial begin
    {rst_n, ds_rd, ds_wr, acc_we, ind_sel, flag_we, carry_in, zero_in} = '0;
    {ds_addr, ds_wdata, acc_wdata, pc_offset, pc_load_value, pc_op, ctx} = '0;
    void'($urandom(32'h01d3));
    repeat (6) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    step();
    for (int i = 0; i < 6; i++) regv[i] = 8'($urandom);
    for (int i = 0; i < 4; i++) acc(1'b1, 8'h80 + 8'(i), regv[i]);
    acc(1'b1, 8'hff, regv[4]);
    page = regv[5] | 8'hc0;
    acc(1'b1, 8'hc9, page);
    for (int i = 0; i < 4; i++) rd(8'h80 + 8'(i), {1'b1, regv[i]});
    rd(8'hff, {1'b1, regv[4]});
    rd(8'hc9, 9'h100);
    rd(8'h00, 9'h000);
    acc(1'b1, 8'h40, 8'h33);
    rd(8'h40, win(6'h00));
    rd(8'h7f, win(6'h3f), 0);
    acc(1'b1, 8'hff, 8'h99);
    rd(8'hff, {1'b1, regv[4]});
    page = 8'($urandom);
    acc(1'b1, 8'hc9, page, 0);
    rd(8'h55, win(6'h15));
    pc_op = 2'b10;
    pc_load_value = 12'hfff;
    step();
    pc_op = 2'b01;
    step();
    pc_op = 2'b11;
    pc_offset = 8'hfe;
    `CHK(program_counter, 12'h000)
    step();
    pc_op = 2'b00;
    ind_sel = 1'b1;
    acc_we = 1'b1;
    acc_wdata = 8'($urandom);
    `CHK(program_counter, 12'hffe)
    step();
    acc_we = 1'b0;
    `CHK(ind_addr, regv[1])
    `CHK(accumulator_reg, acc_wdata)
    `CHK(program_counter, 12'hffe)
    flag_we = 1'b1;
    for (int c = 0; c < 3; c++) begin
      ctx = 2'(c);
      {carry_in, zero_in} = 2'(c + 1);
      step();
    end
    flag_we = 1'b0;
    for (int c = 0; c < 4; c++) begin
      ctx = 2'(c);
      step();
      `CHK({carry, zero}, 2'(c > 2 ? 3 : c + 1))
    end
    repeat (4) @(posedge sys_clk);
    `CHK(exp_q.size(), 0)
    results();
  end
endmodule
bind core_regs_rom_data_window core_regs_checker core_regs_checker_inst(.sys_clk, .rst_n, .ds_addr, .ds_rd, .ds_wr,
  .ds_wdata, .ds_rdata, .ds_rvalid, .ds_hit, .win_busy, .pm_addr, .pm_rd, .acc_we, .accumulator_reg, .ind_sel,
  .ind_addr, .pc_op, .program_counter, .flag_we, .carry_in, .zero_in, .carry, .zero);
